/* File: hw/plc_ctrl.sv */
/*
  Loop clock control: lock-change event flag and interrupt, base clock
  select protection, wait/stop handling, break protection of the flag.
  Assumes all inputs synchronous to CLK; register accesses arrive as
  one-cycle strobes from the CPU side; break and stop come from the
  system integration logic.
*/
`timescale 1ns/10ps
// Behaviour
// - In auto bandwidth mode every lock indicator toggle raises a loop event
// - Interrupt enable gates pending loop event onto the interrupt output
// - Event flag sets on lock change regardless of interrupt enable
// - Auto off: no interrupts, event flag reads zero
// - Loop clock selectable while unlocked; software should check lock first
// - Wait mode changes nothing in the clock generator
// - Stop without oscillator run: oscillator, loop and all clock, enable and irq outputs held low
// - Stop entry with loop clock selected clears base clock select
// - After stop, oscillator drives base clock; select stays clear
// - Stop with oscillator run: loop off, oscillator clock keeps running
// - Break clear enable set: flag cleared in break stays cleared
// - Break clear enable clear: control accesses in break leave flag alone
// - Outside protected break, control read or read-modify-write clears flag
// - Lock indicator reads live in auto mode, zero otherwise
// - Power cannot clear while select set; select cannot set while power off
module plc_ctrl (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic LOCK_IN,
  input wire logic LOOP_CLK_IN,
  input wire logic OSC_CLK_IN,
  input wire logic CTRL_WR,
  input wire logic CTRL_RD,
  input wire logic [7:0] CTRL_WDATA,
  input wire logic BWC_WR,
  input wire logic [7:0] BWC_WDATA,
  input wire logic WAIT_MODE,
  input wire logic STOP_REQ,
  input wire logic STOP_EXIT,
  input wire logic OSC_RUN_IN_STOP,
  input wire logic BREAK_ACTIVE,
  input wire logic BREAK_CLEAR_ENABLE,
  output logic [7:0] CTRL_RDATA,
  output logic [7:0] BWC_RDATA,
  output logic LOOP_POWER_ENABLE,
  output logic BASE_CLOCK_SOURCE_SEL,
  output logic OSC_ENABLE,
  output logic BASE_CLOCK_OUT,
  output logic DIVIDED_LOOP_CLOCK,
  output logic LOOP_OSC_CLOCK,
  output logic OSC_CLOCK,
  output logic CLOCKGEN_IRQ
);
  import plc_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic irq_en_reg;
  logic flag_reg;
  logic pwr_reg;
  logic bcs_reg;
  logic auto_reg;
  logic half_reg;
  logic base_clk_reg;
  plc_pwr_t pwr_state_reg;
  plc_pwr_t pwr_state_next;
  logic lock_q;
  logic lock_change;
  logic flag_set;
  logic flag_clr;
  logic access_clears;
  logic in_stop;
  logic loop_live;
  logic pwr_next;
  logic bcs_next;
  logic osc_off;
  logic src_level;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Level of the clock that currently feeds the base clock divider
  function automatic logic pick_source(input logic sel, input logic loop_lvl, input logic osc_lvl);
    return sel ? loop_lvl : osc_lvl;
  endfunction : pick_source

  plc_lock_edge u_lock (
    .CLK(CLK),
    .RST_N(RST_N),
    .lock_in(LOCK_IN),
    .lock_q(lock_q),
    .change(lock_change)
  );

  // ----------------------------------------------------------------------
  // Low power state; wait mode is deliberately not an input here
  // ----------------------------------------------------------------------
  always_comb begin
    pwr_state_next = pwr_state_reg;
    unique case (pwr_state_reg)
      PLC_RUN: begin
        if (STOP_REQ) begin
          pwr_state_next = OSC_RUN_IN_STOP ? PLC_STOP_XON : PLC_STOP_OFF;
        end
      end
      PLC_STOP_OFF, PLC_STOP_XON: begin
        if (STOP_EXIT) begin
          pwr_state_next = PLC_RUN;
        end
      end
      default: pwr_state_next = PLC_RUN;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pwr_state_reg <= PLC_RUN;
    end else begin
      pwr_state_reg <= pwr_state_next;
    end
  end

  assign in_stop = (pwr_state_reg != PLC_RUN);

  // ----------------------------------------------------------------------
  // Control bits with interlocks
  // ----------------------------------------------------------------------
  always_comb begin
    pwr_next = pwr_reg;
    bcs_next = bcs_reg;
    if (CTRL_WR) begin
      // Lock is not checked here: selecting an unlocked loop is legal
      // Loop is unpowered in stop, so select stays refused there too
      bcs_next = CTRL_WDATA[LCR_BCS_BIT] & pwr_reg & ~in_stop;
      // Power held while select is set or being set, so the pair never splits
      pwr_next = CTRL_WDATA[LCR_PWR_BIT] | bcs_reg | bcs_next;
    end
    if (STOP_REQ && pwr_state_reg == PLC_RUN) begin
      bcs_next = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      irq_en_reg <= RST_IRQ_EN;
    end else if (CTRL_WR) begin
      irq_en_reg <= CTRL_WDATA[LCR_IRQ_EN_BIT];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pwr_reg <= RST_PWR;
    end else begin
      pwr_reg <= pwr_next;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      bcs_reg <= RST_BCS;
    end else begin
      bcs_reg <= bcs_next;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      auto_reg <= RST_AUTO;
    end else if (BWC_WR) begin
      auto_reg <= BWC_WDATA[BWC_AUTO_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Event flag; a lock change in the clearing cycle wins
  // ----------------------------------------------------------------------
  assign flag_set = auto_reg & lock_change;
  // Break with clear disabled shields the flag from accesses
  assign access_clears = (CTRL_RD | CTRL_WR) & (~BREAK_ACTIVE | BREAK_CLEAR_ENABLE);
  assign flag_clr = access_clears | ~auto_reg;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      flag_reg <= RST_FLAG;
    end else if (flag_set) begin
      flag_reg <= 1'b1;
    end else if (flag_clr) begin
      flag_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      CTRL_RDATA <= 8'h00;
    end else begin
      CTRL_RDATA <= 8'h00;
      CTRL_RDATA[LCR_IRQ_EN_BIT] <= irq_en_reg;
      CTRL_RDATA[LCR_FLAG_BIT] <= flag_reg & auto_reg;
      CTRL_RDATA[LCR_PWR_BIT] <= pwr_reg;
      CTRL_RDATA[LCR_BCS_BIT] <= bcs_reg;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      BWC_RDATA <= 8'h00;
    end else begin
      BWC_RDATA <= 8'h00;
      BWC_RDATA[BWC_AUTO_BIT] <= auto_reg;
      BWC_RDATA[BWC_LOCK_BIT] <= lock_q & auto_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Clock gating and outputs
  // ----------------------------------------------------------------------
  assign loop_live = pwr_reg & ~in_stop;
  assign osc_off = (pwr_state_reg == PLC_STOP_OFF);
  assign OSC_ENABLE = ~osc_off;

  // Base clock is half the selected source, toggled on its rising edges
  assign src_level = pick_source(bcs_reg, LOOP_CLK_IN, OSC_CLK_IN);

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      half_reg <= 1'b0;
      base_clk_reg <= 1'b0;
    end else begin
      half_reg <= src_level;
      if (osc_off) begin
        base_clk_reg <= 1'b0;
      end else if (src_level & ~half_reg) begin
        base_clk_reg <= ~base_clk_reg;
      end
    end
  end

  assign BASE_CLOCK_OUT = base_clk_reg;
  assign LOOP_OSC_CLOCK = LOOP_CLK_IN & loop_live;
  assign DIVIDED_LOOP_CLOCK = LOOP_CLK_IN & loop_live;
  assign OSC_CLOCK = OSC_CLK_IN & OSC_ENABLE;
  assign LOOP_POWER_ENABLE = loop_live;
  assign BASE_CLOCK_SOURCE_SEL = bcs_reg;
  assign CLOCKGEN_IRQ = flag_reg & irq_en_reg & auto_reg & ~osc_off;
endmodule : plc_ctrl

/* File: hw/plc_pkg.sv */
/*
  Constants for the loop clock control block: bit positions of the loop
  control and bandwidth control words, and reset values.
  Assumes a single 10 MHz system clock.
*/
package plc_pkg;
  // ----------------------------------------------------------------------
  // Loop control word bit positions
  // ----------------------------------------------------------------------
  localparam int LCR_IRQ_EN_BIT = 7;
  localparam int LCR_FLAG_BIT = 6;
  localparam int LCR_PWR_BIT = 5;
  localparam int LCR_BCS_BIT = 4;
  // ----------------------------------------------------------------------
  // Bandwidth control word bit positions
  // ----------------------------------------------------------------------
  localparam int BWC_AUTO_BIT = 7;
  localparam int BWC_LOCK_BIT = 6;
  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic RST_IRQ_EN = 1'b0;
  localparam logic RST_PWR = 1'b1;
  localparam logic RST_BCS = 1'b0;
  localparam logic RST_AUTO = 1'b0;
  localparam logic RST_FLAG = 1'b0;
  localparam logic RST_LOCK = 1'b0;
  // ----------------------------------------------------------------------
  // Power state encoding
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    PLC_RUN = 3'h1,
    PLC_STOP_OFF = 3'h2,
    PLC_STOP_XON = 3'h4
  } plc_pwr_t;
endpackage : plc_pkg

/* File: hw/plc_lock_edge.sv */
/*
  Lock indicator change detector.
  Assumes lock input is synchronous to CLK.
*/
`timescale 1ns/10ps
module plc_lock_edge (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic lock_in,
  output logic lock_q,
  output logic change
);
  import plc_pkg::*;
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      lock_q <= RST_LOCK;
    end else begin
      lock_q <= lock_in;
    end
  end
  assign change = lock_q ^ lock_in;
endmodule : plc_lock_edge

/* File: bench/plc_ctrl_assertions.sv */
/* Port checker for plc_ctrl.
   Assumes one clock domain and a synchronous active-low reset. */
`timescale 1ns/10ps
module plc_ctrl_chk (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic LOCK_IN,
  input wire logic CTRL_WR,
  input wire logic CTRL_RD,
  input wire logic [7:0] CTRL_WDATA,
  input wire logic BWC_WR,
  input wire logic STOP_REQ,
  input wire logic OSC_RUN_IN_STOP,
  input wire logic BREAK_ACTIVE,
  input wire logic BREAK_CLEAR_ENABLE,
  input wire logic [7:0] CTRL_RDATA,
  input wire logic [7:0] BWC_RDATA,
  input wire logic LOOP_POWER_ENABLE,
  input wire logic BASE_CLOCK_SOURCE_SEL,
  input wire logic OSC_ENABLE,
  input wire logic DIVIDED_LOOP_CLOCK,
  input wire logic CLOCKGEN_IRQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // ----
  // Properties
  // ----
  property p_no_auto; !BWC_RDATA[7] && !$past(BWC_WR) |-> !CLOCKGEN_IRQ && !CTRL_RDATA[6] && !BWC_RDATA[6];
  endproperty
  a_no_auto: assert property (p_no_auto)
    else $error("irq, flag or lock seen with auto off");
  property p_sel_pwr; BASE_CLOCK_SOURCE_SEL |-> LOOP_POWER_ENABLE; endproperty
  a_sel_pwr: assert property (p_sel_pwr)
    else $error("select set with loop off");
  property p_sel_hold; !BASE_CLOCK_SOURCE_SEL && !CTRL_WR |=> !BASE_CLOCK_SOURCE_SEL; endproperty
  a_sel_hold: assert property (p_sel_hold)
    else $error("select rose without a write");
  property p_stop_sel; STOP_REQ && !CTRL_WR |=> !BASE_CLOCK_SOURCE_SEL; endproperty
  a_stop_sel: assert property (p_stop_sel)
    else $error("select kept on stop entry");
  property p_stop_off; STOP_REQ && !OSC_RUN_IN_STOP
    |=> !OSC_ENABLE && !LOOP_POWER_ENABLE && !DIVIDED_LOOP_CLOCK && !CLOCKGEN_IRQ; endproperty
  a_stop_off: assert property (p_stop_off)
    else $error("outputs alive in full stop");
  property p_stop_xon; STOP_REQ && OSC_RUN_IN_STOP |=> OSC_ENABLE && !LOOP_POWER_ENABLE; endproperty
  a_stop_xon: assert property (p_stop_xon)
    else $error("wrong gating in stop with oscillator");
  property p_irq_gate; CTRL_WR && !CTRL_WDATA[7] |=> !CLOCKGEN_IRQ; endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("irq with enable cleared");
  property p_rd_clear; CTRL_RD && !(BREAK_ACTIVE && !BREAK_CLEAR_ENABLE) && !$changed(LOCK_IN)
    |=> !CLOCKGEN_IRQ; endproperty
  a_rd_clear: assert property (p_rd_clear)
    else $error("flag survived a read");
  property p_brk_keep; BREAK_ACTIVE && !BREAK_CLEAR_ENABLE && CTRL_RD && !CTRL_WR && !BWC_WR && !STOP_REQ
    && CLOCKGEN_IRQ |=> CLOCKGEN_IRQ; endproperty
  a_brk_keep: assert property (p_brk_keep)
    else $error("flag lost in protected break");
  property p_lock_flag; BWC_RDATA[7] && !BWC_WR && !$past(BWC_WR) && $changed(LOCK_IN)
    |-> ##2 CTRL_RDATA[6]; endproperty
  a_lock_flag: assert property (p_lock_flag)
    else $error("lock change did not set the flag");
  c_irq: cover property ($rose(CLOCKGEN_IRQ));
  c_xon: cover property (STOP_REQ && OSC_RUN_IN_STOP);
  c_brk: cover property (BREAK_ACTIVE && CTRL_RD && CLOCKGEN_IRQ);
endmodule : plc_ctrl_chk

bind plc_ctrl plc_ctrl_chk i_chk (.CLK, .RST_N, .LOCK_IN, .CTRL_WR, .CTRL_RD, .CTRL_WDATA, .BWC_WR, .STOP_REQ,
  .OSC_RUN_IN_STOP, .BREAK_ACTIVE, .BREAK_CLEAR_ENABLE, .CTRL_RDATA, .BWC_RDATA, .LOOP_POWER_ENABLE,
  .BASE_CLOCK_SOURCE_SEL, .OSC_ENABLE, .DIVIDED_LOOP_CLOCK, .CLOCKGEN_IRQ);

/* File: bench/plc_clk_model.sv */
/* Far-side clock sources: raw oscillator and loop levels.
   Assumes CLK is the block's sampling clock. */
`timescale 1ns/10ps
module plc_clk_model (
  input wire logic CLK,
  output logic OSC_CLK_IN,
  output logic LOOP_CLK_IN
);
  initial begin
    OSC_CLK_IN = 1'b0;
    LOOP_CLK_IN = 1'b0;
  end
  // Loop runs at twice the crystal rate, as a locked loop would
  always @(negedge CLK) begin
    OSC_CLK_IN <= OSC_CLK_IN ^ LOOP_CLK_IN;
    LOOP_CLK_IN <= ~LOOP_CLK_IN;
  end
endmodule : plc_clk_model

/* File: bench/plc_ctrl_tb.sv */
/* Self-checking bench for plc_ctrl.
   Assumes the checker is bound in and inputs change at the falling edge. */
`timescale 1ns/10ps
module plc_ctrl_tb;
  logic CLK = 1'b0, RST_N = 1'b0, LOCK_IN = 1'b0, CTRL_WR = 1'b0, CTRL_RD = 1'b0, BWC_WR = 1'b0;
  logic WAIT_MODE = 1'b0, STOP_REQ = 1'b0, STOP_EXIT = 1'b0, OSC_RUN_IN_STOP = 1'b0;
  logic BREAK_ACTIVE = 1'b0, BREAK_CLEAR_ENABLE = 1'b0, LOOP_CLK_IN, OSC_CLK_IN, LOOP_POWER_ENABLE;
  logic [7:0] CTRL_WDATA = 8'h00, BWC_WDATA = 8'h00, CTRL_RDATA, BWC_RDATA;
  logic BASE_CLOCK_SOURCE_SEL, OSC_ENABLE, BASE_CLOCK_OUT, DIVIDED_LOOP_CLOCK, LOOP_OSC_CLOCK, OSC_CLOCK, CLOCKGEN_IRQ;
  int n_errors = 0;
  int n_tests = 0;
  always #50 CLK = ~CLK;
  plc_clk_model i_clk (.CLK, .OSC_CLK_IN, .LOOP_CLK_IN);
  plc_ctrl i_dut (.*);
  // ----
  // Helpers
  // ----
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge CLK);
  endtask : cyc
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(1);
  endtask : pulse
  task automatic wr(input logic [7:0] d);
    CTRL_WDATA = d;
    pulse(CTRL_WR);
  endtask : wr
  // Counts base clock changes over n cycles
  task automatic count_base(input int n, output int toggles);
    logic prev;
    toggles = 0;
    prev = BASE_CLOCK_OUT;
    repeat (n) begin
      cyc(1);
      if (BASE_CLOCK_OUT !== prev) toggles++;
      prev = BASE_CLOCK_OUT;
    end
  endtask : count_base
  // Packed view: irq, oscillator, loop power, select
  function automatic logic [7:0] st();
    return {4'h0, CLOCKGEN_IRQ, OSC_ENABLE, LOOP_POWER_ENABLE, BASE_CLOCK_SOURCE_SEL};
  endfunction : st
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // ----
  // Scenarios
  // ----
  task automatic t_lock();
    LOCK_IN = 1'b1;
    cyc(3);
    chk("state", 8'h06, st());
    chk("ctrl", 8'h20, CTRL_RDATA);
    chk("bwc", 8'h00, BWC_RDATA);
    BWC_WDATA = 8'h80;
    pulse(BWC_WR);
    wr(8'h20);
    LOCK_IN = 1'b0;
    cyc(3);
    chk("state", 8'h06, st());
    chk("ctrl", 8'h60, CTRL_RDATA);
    chk("bwc", 8'h80, BWC_RDATA);
    wr(8'hA0);
    LOCK_IN = 1'b1;
    cyc(2);
    chk("state", 8'h0E, st());
    chk("bwc", 8'hC0, BWC_RDATA);
    BREAK_ACTIVE = 1'b1;
    pulse(CTRL_RD);
    wr(8'hA0);
    chk("state", 8'h0E, st());
    BREAK_CLEAR_ENABLE = 1'b1;
    pulse(CTRL_RD);
    BREAK_ACTIVE = 1'b0;
    BREAK_CLEAR_ENABLE = 1'b0;
    cyc(2);
    chk("state", 8'h06, st());
    LOCK_IN = 1'b0;
    cyc(2);
    chk("state", 8'h0E, st());
    pulse(CTRL_RD);
    chk("state", 8'h06, st());
    LOCK_IN = 1'b1;
    cyc(2);
    BWC_WDATA = 8'h00;
    pulse(BWC_WR);
    chk("state", 8'h06, st());
    chk("ctrl", 8'hA0, CTRL_RDATA);
    $display("lock test done");
  endtask : t_lock
  task automatic t_sel();
    int tg;
    wr(8'h00);
    chk("state", 8'h04, st());
    wr(8'h10);
    chk("state", 8'h04, st());
    wr(8'h30);
    chk("state", 8'h06, st());
    wr(8'h30);
    chk("state", 8'h07, st());
    wr(8'h10);
    chk("state", 8'h07, st());
    WAIT_MODE = 1'b1;
    cyc(4);
    chk("state", 8'h07, st());
    count_base(16, tg);
    chk("base toggles", 8'h08, 8'(tg));
    wr(8'h20);
    wr(8'h00);
    chk("state", 8'h04, st());
    WAIT_MODE = 1'b0;
    $display("select test done");
  endtask : t_sel
  task automatic t_stop();
    int seen;
    int tg;
    wr(8'h20);
    wr(8'h30);
    pulse(STOP_REQ);
    chk("state", 8'h00, st());
    repeat (4) begin
      cyc(1);
      chk("clocks", 8'h00, {4'h0, BASE_CLOCK_OUT, DIVIDED_LOOP_CLOCK, LOOP_OSC_CLOCK, OSC_CLOCK});
    end
    pulse(STOP_EXIT);
    cyc(1);
    chk("state", 8'h06, st());
    chk("ctrl", 8'h20, CTRL_RDATA);
    count_base(16, tg);
    chk("base toggles", 8'h04, 8'(tg));
    wr(8'h30);
    OSC_RUN_IN_STOP = 1'b1;
    pulse(STOP_REQ);
    chk("state", 8'h04, st());
    seen = 0;
    for (int i = 0; i < 8 && seen == 0; i++) begin
      cyc(1);
      if (OSC_CLOCK === 1'b1 && LOOP_OSC_CLOCK === 1'b0) seen = 1;
    end
    chk("osc run", 8'h01, 8'(seen));
    pulse(STOP_EXIT);
    $display("stop test done");
  endtask : t_stop
  initial begin
    cyc(2);
    RST_N = 1'b1;
    cyc(2);
    chk("state", 8'h06, st());
    t_lock();
    t_sel();
    t_stop();
    wrap_up();
  end
endmodule : plc_ctrl_tb
